// file: rtl/vps_pkg.sv
package vps_pkg;
	// ------------------------------------------------------------------
	// sizes and reset values
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 9;
	localparam logic [ADDR_W-1:0] RST_START = 8'h00;
	localparam logic [ADDR_W-1:0] RST_LOOP = 8'h00;
	localparam logic [ADDR_W-1:0] RST_END = 8'h07;
	localparam logic [1:0] RST_VEC_RADIX = 2'h0;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int STARTUP_NS = 130;
	localparam int GAP_NS = 15000;
	// startup is a least time, rounded up; gap rounded down
	localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = GAP_NS / CLK_NS;
	localparam logic [CNT_W-1:0] STARTUP_LOAD = CNT_W'(STARTUP_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);

	// ------------------------------------------------------------------
	// run modes and sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_BURST = 2'h0,
		MODE_AUTO_BURST = 2'h1,
		MODE_AUTO = 2'h2,
		MODE_TRIG_AUTO = 2'h3
	} vps_mode_t;
	localparam vps_mode_t RST_MODE = MODE_AUTO;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_DELAY,
		ST_PLAY,
		ST_GAP
	} vps_state_t;
endpackage : vps_pkg

// file: rtl/vps_buf2.sv
`timescale 1ns/10ps
module vps_buf2 #(
	parameter int WIDTH = 4
) (
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset, high
	input wire logic [WIDTH-1:0] i_data, // word in
	input wire logic i_valid, // word offered
	output logic o_ready, // room for a word
	output logic [WIDTH-1:0] o_data, // head word
	output logic o_valid, // head word valid
	input wire logic i_ready // sink takes head
);
	logic [WIDTH-1:0] head_reg, head_next;
	logic [WIDTH-1:0] tail_reg, tail_next;
	logic [1:0] cnt_reg, cnt_next;
	logic valid_reg, valid_next;
	logic push, pop;

	assign o_ready = (cnt_reg != 2'h2);
	assign o_data = head_reg;
	assign o_valid = valid_reg;

	always_comb begin
		push = i_valid && o_ready;
		pop = valid_reg && i_ready;
		head_next = head_reg;
		tail_next = tail_reg;
		cnt_next = cnt_reg;
		unique case ({push, pop})
			2'b10: begin
				if (cnt_reg == 2'h0) begin
					head_next = i_data;
				end else begin
					tail_next = i_data;
				end
				cnt_next = cnt_reg + 2'h1;
			end
			2'b01: begin
				head_next = tail_reg;
				cnt_next = cnt_reg - 2'h1;
			end
			2'b11: begin
				// count is one here: the new word becomes the head
				head_next = i_data;
			end
			default: begin
			end
		endcase
		valid_next = (cnt_next != 2'h0);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			head_reg <= '0;
			tail_reg <= '0;
			cnt_reg <= 2'h0;
			valid_reg <= 1'b0;
		end else begin
			head_reg <= head_next;
			tail_reg <= tail_next;
			cnt_reg <= cnt_next;
			valid_reg <= valid_next;
		end
	end
endmodule : vps_buf2

// file: rtl/vps_sequencer.sv
// Overview of operation
// - first vector of a sequence comes from the start address.
// - last vector of each pass comes from the end address.
// - continuous modes start later passes at the loop address.
// - burst modes ignore loop; each burst runs start to end.
// - start, loop, end, mode and vector radix are shared by all channels.
// - single-shot mode idles until an external, button or command trigger.
// - single-shot waits at least 130 ns (4 cycles, 160 ns) after trigger before first vector.
// - single-shot plays start to end once, then waits for a trigger.
// - self-triggered bursts repeat with about 15 us between them.
// - free-running starts at start vector at once, no delay.
// - continuous modes wrap from end to loop without a gap.
// - continuous output runs until a stop request arrives.
// - triggered free-running waits for a trigger, then free-runs.
// - on stop, the address returns to the start vector; queued words still drain.
// - a block is start plus end or size; fill and clear act on it.
// - an entered digit overwrites the datum and moves the cursor on.
// - clear zeroes one channel, or every channel in group view.
`timescale 1ns/10ps
module vps_sequencer #(
	parameter int ADDR_W = vps_pkg::ADDR_W,
	parameter int NUM_CH = vps_pkg::NUM_CH
) (
	input wire logic I_REF_CLK, // 25 MHz clock
	input wire logic I_RST, // sync reset, high
	input wire logic I_TRIG_EXT, // trigger pin, async
	input wire logic I_TRIG_BTN, // trigger button, async
	input wire logic I_TRIG_CMD, // remote trigger pulse
	input wire logic I_RUN, // start output pulse
	input wire logic I_STOP, // stop output pulse
	input wire logic I_CFG_WR, // config write pulse
	input wire logic [1:0] I_CFG_CH, // channel of the write
	input wire logic [1:0] I_MODE, // run mode
	input wire logic [ADDR_W-1:0] I_START, // start address
	input wire logic [ADDR_W-1:0] I_LOOP, // loop address
	input wire logic [ADDR_W-1:0] I_END, // end address
	input wire logic [1:0] I_VEC_RADIX, // vector radix
	input wire logic I_DATA_HEX, // channel data radix hex
	input wire logic I_CUR_LOAD, // cursor load pulse
	input wire logic [ADDR_W-1:0] I_CUR_ADDR, // cursor vector
	input wire logic [1:0] I_CUR_CH, // cursor channel
	input wire logic I_DIGIT_WR, // digit entered pulse
	input wire logic [NUM_CH-1:0] I_DIGIT, // digit value
	input wire logic I_BLK_CLEAR, // clear block pulse
	input wire logic I_BLK_FILL, // fill block pulse
	input wire logic [ADDR_W-1:0] I_BLK_START, // block start
	input wire logic [ADDR_W-1:0] I_BLK_END, // block end
	input wire logic [ADDR_W-1:0] I_BLK_SIZE, // block size
	input wire logic I_BLK_USE_SIZE, // use size, not end
	input wire logic I_BLK_GROUP, // group view
	input wire logic [1:0] I_BLK_CH, // block channel
	input wire logic I_FILL_VAL, // fill bit value
	input wire logic I_DUT_READY, // receiver takes word
	output logic [NUM_CH-1:0] O_DATA, // channel data bits
	output logic O_VALID, // data word valid
	output logic O_RUNNING, // sequencer active
	output logic [ADDR_W-1:0] O_ADDR, // sequencer address
	output logic [1:0] O_MODE, // shared mode
	output logic [1:0] O_VEC_RADIX, // shared vector radix
	output logic O_BLK_BUSY, // block op running
	output logic [ADDR_W-1:0] O_CUR_ADDR, // cursor vector
	output logic [1:0] O_CUR_CH // cursor channel
);
	localparam int DEPTH = 1 << ADDR_W;

	function automatic logic [NUM_CH-1:0] ch_mask(input logic [1:0] ch,
		input logic all);
		logic [NUM_CH-1:0] m;
		m = '0;
		m[ch] = 1'b1;
		if (all) begin
			m = '1;
		end
		return m;
	endfunction : ch_mask

	// ------------------------------------------------------------------
	// trigger synchronisers
	// ------------------------------------------------------------------
	logic [2:0] ext_reg, ext_next;
	logic [2:0] btn_reg, btn_next;
	logic trig_any;

	always_comb begin
		ext_next = {ext_reg[1:0], I_TRIG_EXT};
		btn_next = {btn_reg[1:0], I_TRIG_BTN};
		// edge taken from second and third stages only
		trig_any = (ext_reg[1] && !ext_reg[2]) ||
			(btn_reg[1] && !btn_reg[2]) || I_TRIG_CMD;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			ext_reg <= 3'h0;
			btn_reg <= 3'h0;
		end else begin
			ext_reg <= ext_next;
			btn_reg <= btn_next;
		end
	end

	// ------------------------------------------------------------------
	// shared settings and per-channel data radix
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] start_reg, start_next, loop_reg, loop_next;
	logic [ADDR_W-1:0] end_reg, end_next;
	vps_pkg::vps_mode_t mode_reg, mode_next;
	logic [1:0] vrad_reg, vrad_next;
	logic [NUM_CH-1:0] hex_reg, hex_next;

	always_comb begin
		start_next = start_reg;
		loop_next = loop_reg;
		end_next = end_reg;
		mode_next = mode_reg;
		vrad_next = vrad_reg;
		hex_next = hex_reg;
		if (I_CFG_WR) begin
			start_next = I_START;
			loop_next = I_LOOP;
			end_next = I_END;
			mode_next = vps_pkg::vps_mode_t'(I_MODE);
			vrad_next = I_VEC_RADIX;
			hex_next[I_CFG_CH] = I_DATA_HEX;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			start_reg <= vps_pkg::RST_START;
			loop_reg <= vps_pkg::RST_LOOP;
			end_reg <= vps_pkg::RST_END;
			mode_reg <= vps_pkg::RST_MODE;
			vrad_reg <= vps_pkg::RST_VEC_RADIX;
			hex_reg <= '1;
		end else begin
			start_reg <= start_next;
			loop_reg <= loop_next;
			end_reg <= end_next;
			mode_reg <= mode_next;
			vrad_reg <= vrad_next;
			hex_reg <= hex_next;
		end
	end

	// ------------------------------------------------------------------
	// vector storage, block engine and editor
	// ------------------------------------------------------------------
	logic [NUM_CH-1:0] mem_reg [DEPTH];
	logic [NUM_CH-1:0] mem_next [DEPTH];
	logic blk_reg, blk_next;
	logic [ADDR_W-1:0] baddr_reg, baddr_next, blast_reg, blast_next;
	logic [NUM_CH-1:0] bmask_reg, bmask_next;
	logic bval_reg, bval_next;
	logic [ADDR_W-1:0] cur_reg, cur_next;
	logic [1:0] cch_reg, cch_next;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [NUM_CH-1:0] wr_mask, wr_data;
	vps_pkg::vps_state_t state_reg;

	always_comb begin
		blk_next = blk_reg;
		baddr_next = baddr_reg;
		blast_next = blast_reg;
		bmask_next = bmask_reg;
		bval_next = bval_reg;
		cur_next = cur_reg;
		cch_next = cch_reg;
		wr_en = 1'b0;
		wr_addr = baddr_reg;
		wr_mask = bmask_reg;
		wr_data = {NUM_CH{bval_reg}};
		if (blk_reg) begin
			wr_en = 1'b1;
			baddr_next = baddr_reg + 1'b1;
			blk_next = (baddr_reg != blast_reg);
		end else if (state_reg == vps_pkg::ST_IDLE &&
			(I_BLK_CLEAR || I_BLK_FILL)) begin
			// block from start plus end or size
			blk_next = 1'b1;
			baddr_next = I_BLK_START;
			blast_next = I_BLK_USE_SIZE ?
				ADDR_W'(I_BLK_START + I_BLK_SIZE - 1'b1) : I_BLK_END;
			// clear zeroes channel or whole group
			bmask_next = ch_mask(I_BLK_CH, I_BLK_GROUP);
			bval_next = I_BLK_FILL && I_FILL_VAL;
		end else if (I_CUR_LOAD) begin
			cur_next = I_CUR_ADDR;
			cch_next = I_CUR_CH;
		end else if (I_DIGIT_WR && state_reg == vps_pkg::ST_IDLE) begin
			wr_en = 1'b1;
			wr_addr = cur_reg;
			wr_mask = ch_mask(cch_reg, hex_reg[cch_reg]);
			wr_data = hex_reg[cch_reg] ? I_DIGIT : {NUM_CH{I_DIGIT[0]}};
			cur_next = cur_reg + 1'b1;
		end
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (wr_en) begin
			mem_next[wr_addr] = (mem_reg[wr_addr] & ~wr_mask) |
				(wr_data & wr_mask);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			blk_reg <= 1'b0;
			baddr_reg <= '0;
			blast_reg <= '0;
			bmask_reg <= '0;
			bval_reg <= 1'b0;
			cur_reg <= '0;
			cch_reg <= 2'h0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			blk_reg <= blk_next;
			baddr_reg <= baddr_next;
			blast_reg <= blast_next;
			bmask_reg <= bmask_next;
			bval_reg <= bval_next;
			cur_reg <= cur_next;
			cch_reg <= cch_next;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	vps_pkg::vps_state_t state_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [vps_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic run_reg, run_next;
	logic buf_ready, push, at_end, contin;

	always_comb begin
		contin = (mode_reg == vps_pkg::MODE_AUTO) ||
			(mode_reg == vps_pkg::MODE_TRIG_AUTO);
		at_end = (addr_reg == end_reg);
		push = (state_reg == vps_pkg::ST_PLAY) && buf_ready;
		state_next = state_reg;
		addr_next = addr_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			vps_pkg::ST_IDLE: begin
				addr_next = start_reg;
				if (I_RUN) begin
					unique case (mode_reg)
						vps_pkg::MODE_AUTO: state_next = vps_pkg::ST_PLAY;
						vps_pkg::MODE_AUTO_BURST: begin
							state_next = vps_pkg::ST_DELAY;
							cnt_next = vps_pkg::STARTUP_LOAD;
						end
						default: state_next = vps_pkg::ST_WAIT;
					endcase
				end
			end
			vps_pkg::ST_WAIT: begin
				if (trig_any) begin
					if (mode_reg == vps_pkg::MODE_TRIG_AUTO) begin
						state_next = vps_pkg::ST_PLAY;
					end else begin
						state_next = vps_pkg::ST_DELAY;
						cnt_next = vps_pkg::STARTUP_LOAD;
					end
				end
			end
			vps_pkg::ST_DELAY: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == '0) begin
					state_next = vps_pkg::ST_PLAY;
				end
			end
			vps_pkg::ST_PLAY: begin
				// triggers not looked at while playing
				if (push) begin
					// one vector per period, shared address
					addr_next = addr_reg + 1'b1;
					if (at_end) begin
						// pass ends on the end vector
						if (contin) begin
							addr_next = loop_reg;
						end else begin
							addr_next = start_reg;
							if (mode_reg == vps_pkg::MODE_BURST) begin
								state_next = vps_pkg::ST_WAIT;
							end else begin
								state_next = vps_pkg::ST_GAP;
								cnt_next = vps_pkg::GAP_LOAD;
							end
						end
					end
				end
			end
			vps_pkg::ST_GAP: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == '0) begin
					state_next = vps_pkg::ST_DELAY;
					cnt_next = vps_pkg::STARTUP_LOAD;
				end
			end
		endcase
		// stop sends the sequencer to idle, which reloads the start address
		if (I_STOP) begin
			state_next = vps_pkg::ST_IDLE;
		end
		run_next = (state_next != vps_pkg::ST_IDLE);
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			state_reg <= vps_pkg::ST_IDLE;
			addr_reg <= vps_pkg::RST_START;
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end

	vps_buf2 #(
		.WIDTH(NUM_CH)
	) u_buf (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		// words come from the sequencer address
		.i_data(mem_reg[addr_reg]),
		.i_valid(state_reg == vps_pkg::ST_PLAY),
		.o_ready(buf_ready),
		.o_data(O_DATA),
		.o_valid(O_VALID),
		.i_ready(I_DUT_READY)
	);

	assign O_RUNNING = run_reg;
	assign O_ADDR = addr_reg;
	assign O_MODE = mode_reg;
	assign O_VEC_RADIX = vrad_reg;
	assign O_BLK_BUSY = blk_reg;
	assign O_CUR_ADDR = cur_reg;
	assign O_CUR_CH = cch_reg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	// cycles spent in the gap so far, for the gap length check
	logic [vps_pkg::CNT_W-1:0] gseen_reg, gseen_next;

	always_comb begin
		gseen_next = '0;
		if (state_reg == vps_pkg::ST_GAP) begin
			gseen_next = gseen_reg + 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			gseen_reg <= '0;
		end else begin
			gseen_reg <= gseen_next;
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);

	first_start_a: assert property (
		$rose(state_reg == vps_pkg::ST_PLAY) |-> addr_reg == start_reg)
		else $error("play did not begin at start");
	burst_end_a: assert property (
		push && at_end && !contin && !I_STOP |=>
		state_reg != vps_pkg::ST_PLAY && addr_reg == start_reg)
		else $error("burst did not end on end vector");
	loop_wrap_a: assert property (
		push && at_end && contin && !I_STOP |=>
		state_reg == vps_pkg::ST_PLAY && addr_reg == loop_reg)
		else $error("continuous pass did not wrap to loop");
	shared_cfg_a: assert property (
		I_CFG_WR |=> start_reg == $past(I_START) &&
		end_reg == $past(I_END) && loop_reg == $past(I_LOOP))
		else $error("shared settings not taken");
	trig_wait_a: assert property (
		state_reg == vps_pkg::ST_WAIT && !trig_any && !I_STOP |=>
		state_reg == vps_pkg::ST_WAIT)
		else $error("left wait without a trigger");
	startup_a: assert property (disable iff (I_RST || I_STOP)
		state_reg == vps_pkg::ST_WAIT && trig_any &&
		mode_reg == vps_pkg::MODE_BURST |=>
		(state_reg == vps_pkg::ST_DELAY) [*4] ##1
		state_reg == vps_pkg::ST_PLAY)
		else $error("startup delay wrong");
	gap_len_a: assert property (
		state_reg == vps_pkg::ST_GAP && gseen_reg == vps_pkg::GAP_LOAD &&
		!I_STOP |=> state_reg == vps_pkg::ST_DELAY)
		else $error("burst gap too long");
	gap_hold_a: assert property (
		state_reg == vps_pkg::ST_GAP && gseen_reg != vps_pkg::GAP_LOAD &&
		!I_STOP |=> state_reg == vps_pkg::ST_GAP)
		else $error("burst gap too short");
	free_run_a: assert property (
		state_reg == vps_pkg::ST_IDLE && I_RUN && !I_STOP &&
		mode_reg == vps_pkg::MODE_AUTO |=>
		state_reg == vps_pkg::ST_PLAY && addr_reg == start_reg)
		else $error("free run did not start at once");
	stop_idle_a: assert property (
		I_STOP |=> state_reg == vps_pkg::ST_IDLE && !O_RUNNING)
		else $error("stop not obeyed");
	trig_auto_a: assert property (
		state_reg == vps_pkg::ST_WAIT && trig_any && !I_STOP &&
		mode_reg == vps_pkg::MODE_TRIG_AUTO |=>
		state_reg == vps_pkg::ST_PLAY)
		else $error("triggered free run did not start");
	addr_step_a: assert property (
		push && !at_end && !I_STOP |=> addr_reg == $past(addr_reg) + 1'b1)
		else $error("address did not step by one");
	trig_ignore_a: assert property (
		state_reg == vps_pkg::ST_PLAY && trig_any && !at_end &&
		!I_STOP |=> state_reg == vps_pkg::ST_PLAY)
		else $error("trigger disturbed a burst");

	burst_done_c: cover property (push && at_end &&
		mode_reg == vps_pkg::MODE_BURST);
	gap_done_c: cover property (state_reg == vps_pkg::ST_GAP &&
		cnt_reg == '0);
	wrap_c: cover property (push && at_end && contin);
	stall_c: cover property (state_reg == vps_pkg::ST_PLAY && !buf_ready);
endmodule : vps_sequencer

// file: verification/vps_dut_model.sv
`timescale 1ns/10ps
module vps_dut_model (
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset, high
	input wire logic [vps_pkg::NUM_CH-1:0] i_data, // channel bits
	input wire logic i_valid, // word offered
	input wire logic i_slow, // stall every other cycle
	output logic o_ready // word taken
);
	// ------------------------------------------------------------------
	// receiver: takes words, records them with the cycle of capture
	// ------------------------------------------------------------------
	logic [vps_pkg::NUM_CH-1:0] words[$];
	int stamps[$];
	int cyc = 0;
	logic ph = 1'b0;

	// slow receiver drops ready on alternate cycles
	assign o_ready = !i_slow || ph;

	always @(negedge i_clk) begin
		ph <= ~ph;
	end

	// one word is all channels of one vector
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (!i_rst && i_valid && o_ready) begin
			words.push_back(i_data);
			stamps.push_back(cyc);
		end
	end
endmodule : vps_dut_model

// file: verification/test_vector_pattern_sequencer.sv
`timescale 1ns/10ps
module test_vector_pattern_sequencer;
	logic I_REF_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_TRIG_EXT = 1'b0, I_TRIG_BTN = 1'b0, I_TRIG_CMD = 1'b0;
	logic I_RUN = 1'b0, I_STOP = 1'b0, I_CFG_WR = 1'b0, I_DATA_HEX = 1'b1;
	logic [1:0] I_CFG_CH = 2'h0, I_MODE = 2'h2, I_VEC_RADIX = 2'h0;
	logic [7:0] I_START = 8'h00, I_LOOP = 8'h00, I_END = 8'h07;
	logic I_CUR_LOAD = 1'b0, I_DIGIT_WR = 1'b0;
	logic [7:0] I_CUR_ADDR = 8'h00, I_BLK_START = 8'h00;
	logic [7:0] I_BLK_END = 8'h00, I_BLK_SIZE = 8'h01;
	logic [1:0] I_CUR_CH = 2'h0, I_BLK_CH = 2'h0;
	logic [3:0] I_DIGIT = 4'h0;
	logic I_BLK_CLEAR = 1'b0, I_BLK_FILL = 1'b0, I_BLK_USE_SIZE = 1'b0;
	logic I_BLK_GROUP = 1'b0, I_FILL_VAL = 1'b0, I_DUT_READY, slow = 1'b0;
	logic [3:0] O_DATA;
	logic O_VALID, O_RUNNING, O_BLK_BUSY;
	logic [7:0] O_ADDR, O_CUR_ADDR;
	logic [1:0] O_MODE, O_VEC_RADIX, O_CUR_CH;
	logic [3:0] emem [256] = '{default: 4'h0};
	int n_fail = 0, n_checks = 0, cyc_count = 0;

	vps_sequencer vps_sequencer_inst (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
		.I_TRIG_EXT(I_TRIG_EXT), .I_TRIG_BTN(I_TRIG_BTN),
		.I_TRIG_CMD(I_TRIG_CMD), .I_RUN(I_RUN), .I_STOP(I_STOP),
		.I_CFG_WR(I_CFG_WR), .I_CFG_CH(I_CFG_CH), .I_MODE(I_MODE),
		.I_START(I_START), .I_LOOP(I_LOOP), .I_END(I_END),
		.I_VEC_RADIX(I_VEC_RADIX), .I_DATA_HEX(I_DATA_HEX),
		.I_CUR_LOAD(I_CUR_LOAD), .I_CUR_ADDR(I_CUR_ADDR),
		.I_CUR_CH(I_CUR_CH), .I_DIGIT_WR(I_DIGIT_WR), .I_DIGIT(I_DIGIT),
		.I_BLK_CLEAR(I_BLK_CLEAR), .I_BLK_FILL(I_BLK_FILL),
		.I_BLK_START(I_BLK_START), .I_BLK_END(I_BLK_END),
		.I_BLK_SIZE(I_BLK_SIZE), .I_BLK_USE_SIZE(I_BLK_USE_SIZE),
		.I_BLK_GROUP(I_BLK_GROUP), .I_BLK_CH(I_BLK_CH),
		.I_FILL_VAL(I_FILL_VAL), .I_DUT_READY(I_DUT_READY),
		.O_DATA(O_DATA), .O_VALID(O_VALID), .O_RUNNING(O_RUNNING),
		.O_ADDR(O_ADDR), .O_MODE(O_MODE), .O_VEC_RADIX(O_VEC_RADIX),
		.O_BLK_BUSY(O_BLK_BUSY), .O_CUR_ADDR(O_CUR_ADDR),
		.O_CUR_CH(O_CUR_CH));

	vps_dut_model vps_dut_model_inst (.i_clk(I_REF_CLK), .i_rst(I_RST),
		.i_data(O_DATA), .i_valid(O_VALID), .i_slow(slow),
		.o_ready(I_DUT_READY));

	initial begin
		forever #20 I_REF_CLK = ~I_REF_CLK;
	end

	always @(posedge I_REF_CLK) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 20000) begin
			n_fail = n_fail + 1;
			conclude();
		end
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic conclude();
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [15:0] ex,
		input logic [15:0] got);
		n_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic chk_word(input logic [3:0] ex, input logic [3:0] got);
		n_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("Error data word expected %h seen %h", ex, got);
		end
	endtask : chk_word

	task automatic cyc(input int n);
		repeat (n) @(negedge I_REF_CLK);
	endtask : cyc

	task automatic cfg(input logic [1:0] md, input logic [7:0] s, l, e,
		input logic [1:0] ch, input logic hex);
		I_MODE = md;
		I_START = s;
		I_LOOP = l;
		I_END = e;
		I_VEC_RADIX = ~md;
		I_CFG_CH = ch;
		I_DATA_HEX = hex;
		I_CFG_WR = 1'b1;
		cyc(1);
		I_CFG_WR = 1'b0;
		chk("mode", 16'(md), 16'(O_MODE));
		chk("vec_radix", 16'(I_VEC_RADIX), 16'(O_VEC_RADIX));
	endtask : cfg

	task automatic load(input logic [7:0] a, input logic [1:0] ch);
		I_CUR_ADDR = a;
		I_CUR_CH = ch;
		I_CUR_LOAD = 1'b1;
		cyc(1);
		I_CUR_LOAD = 1'b0;
	endtask : load

	task automatic dig(input logic [3:0] d);
		I_DIGIT = d;
		I_DIGIT_WR = 1'b1;
		cyc(1);
		I_DIGIT_WR = 1'b0;
		cyc(1);
	endtask : dig

	task automatic blk(input logic fill, input logic [7:0] s, es,
		input logic use_sz, grp, input logic [1:0] ch, input logic v);
		int k;
		logic [7:0] a;
		I_BLK_START = s;
		I_BLK_END = use_sz ? s : es;
		I_BLK_SIZE = use_sz ? es : 8'h01;
		I_BLK_USE_SIZE = use_sz;
		I_BLK_GROUP = grp;
		I_BLK_CH = ch;
		I_FILL_VAL = v;
		I_BLK_FILL = fill;
		I_BLK_CLEAR = !fill;
		cyc(1);
		I_BLK_FILL = 1'b0;
		I_BLK_CLEAR = 1'b0;
		chk("blk_busy", 16'h1, 16'(O_BLK_BUSY));
		for (k = 0; k < 300 && O_BLK_BUSY !== 1'b0; k++) cyc(1);
		a = s;
		for (k = 0; k < (use_sz ? es : es - s + 1); k++) begin
			if (grp) emem[a] = fill ? {4{v}} : 4'h0;
			else emem[a][ch] = fill & v;
			a++;
		end
	endtask : blk

	task automatic trig(input int tk, output int t0);
		I_TRIG_CMD = tk == 1;
		I_TRIG_EXT = tk == 2;
		I_TRIG_BTN = tk == 3;
		t0 = vps_dut_model_inst.cyc;
		cyc(1);
		I_TRIG_CMD = 1'b0;
		cyc(3);
		I_TRIG_EXT = 1'b0;
		I_TRIG_BTN = 1'b0;
	endtask : trig

	task automatic run(input logic [1:0] md, input logic [7:0] s, l, e,
		input int tk, input int n, input logic sl);
		int t0;
		int k;
		int m;
		logic re;
		logic cont;
		logic [7:0] a;
		cfg(md, s, l, e, 2'h3, 1'b1);
		cont = md == vps_pkg::MODE_AUTO || md == vps_pkg::MODE_TRIG_AUTO;
		slow = sl;
		vps_dut_model_inst.words.delete();
		vps_dut_model_inst.stamps.delete();
		re = 1'b0;
		I_RUN = 1'b1;
		t0 = vps_dut_model_inst.cyc;
		cyc(1);
		I_RUN = 1'b0;
		if (tk != 0) begin
			cyc(12);
			chk("early", 16'h0, 16'(vps_dut_model_inst.words.size()));
			trig(tk, t0);
		end
		for (k = 0; k < 2000 && vps_dut_model_inst.words.size() < n; k++) begin
			I_TRIG_CMD = md == vps_pkg::MODE_BURST && !re &&
				vps_dut_model_inst.words.size() == 1;
			re |= I_TRIG_CMD;
			cyc(1);
		end
		I_TRIG_CMD = 1'b0;
		if (md == vps_pkg::MODE_BURST) begin
			cyc(20);
			chk("burst_len", 16'(n), 16'(vps_dut_model_inst.words.size()));
		end
		I_STOP = 1'b1;
		cyc(1);
		I_STOP = 1'b0;
		cyc(8);
		chk("running", 16'h0, 16'(O_RUNNING));
		chk("idle_addr", 16'(s), 16'(O_ADDR));
		m = vps_dut_model_inst.words.size();
		cyc(10);
		chk("drained", 16'(m), 16'(vps_dut_model_inst.words.size()));
		a = s;
		for (k = 0; k < n; k++) begin
			chk_word(emem[a], vps_dut_model_inst.words[k]);
			a = (a != e) ? a + 8'h1 : (cont ? l : s);
		end
		m = vps_dut_model_inst.stamps[e-s+1] - vps_dut_model_inst.stamps[e-s];
		if (cont && !sl) chk("wrap_gap", 16'h1, 16'(m));
		if (md == vps_pkg::MODE_AUTO_BURST) chk("gap", 16'h1, 16'(m >= 375 && m <= 400));
		m = vps_dut_model_inst.stamps[0] - t0;
		if (md == vps_pkg::MODE_BURST) chk("delay", 16'h1, 16'(m >= 4 && m <= 12));
		if (md == vps_pkg::MODE_AUTO && !sl) chk("start_lat", 16'h1, 16'(m <= 2));
		if (md == vps_pkg::MODE_TRIG_AUTO) chk("trig_lat", 16'h1, 16'(m <= 3));
	endtask : run

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		cyc(6);
		I_RST = 1'b0;
		cyc(1);
		chk("rst_mode", 16'h2, 16'(O_MODE));
		chk("rst_valid", 16'h0, 16'({O_VALID, O_RUNNING, O_CUR_ADDR}));
		load(8'h00, 2'h0);
		for (int d = 1; d <= 8; d++) begin
			dig(4'(d));
			emem[d-1] = 4'(d);
		end
		chk("cursor", 16'h8, 16'(O_CUR_ADDR));
		cfg(vps_pkg::MODE_AUTO, 8'h00, 8'h00, 8'h07, 2'h2, 1'b0);
		load(8'h00, 2'h2);
		dig(4'hf);
		dig(4'h0);
		emem[0][2] = 1'b1;
		chk("cursor_bin", 16'h0202, 16'({O_CUR_ADDR, 6'h0, O_CUR_CH}));
		blk(1'b0, 8'h05, 8'h06, 1'b0, 1'b1, 2'h0, 1'b0);
		blk(1'b0, 8'h02, 8'h02, 1'b1, 1'b0, 2'h1, 1'b0);
		blk(1'b1, 8'h07, 8'h01, 1'b1, 1'b1, 2'h0, 1'b1);
		blk(1'b1, 8'h00, 8'h01, 1'b0, 1'b0, 2'h3, 1'b1);
		run(vps_pkg::MODE_AUTO, 8'h00, 8'h02, 8'h07, 0, 14, 1'b1);
		run(vps_pkg::MODE_AUTO, 8'h03, 8'h03, 8'h05, 0, 7, 1'b0);
		run(vps_pkg::MODE_BURST, 8'h01, 8'h03, 8'h04, 1, 4, 1'b0);
		run(vps_pkg::MODE_BURST, 8'h00, 8'h05, 8'h02, 2, 3, 1'b0);
		run(vps_pkg::MODE_BURST, 8'h04, 8'h04, 8'h07, 3, 4, 1'b0);
		run(vps_pkg::MODE_AUTO_BURST, 8'h02, 8'h03, 8'h04, 0, 6, 1'b0);
		run(vps_pkg::MODE_TRIG_AUTO, 8'h00, 8'h06, 8'h07, 1, 10, 1'b0);
		conclude();
	end
endmodule : test_vector_pattern_sequencer
